// ===== inc/acs_pkg.sv
package acs_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned CAL_TIME_MS   = 41;
   localparam int unsigned CAL_CYCLES    = (CAL_TIME_MS * 1000000) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTRL_OFFSET = 8'h00;
   localparam logic [7:0]  CTRL_LAST   = 8'h0E;
   localparam logic [7:0]  STAT_OFFSET = 8'h10;
   localparam logic [15:0] CTRL_RESET  = 16'h0000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Scan sizes
   // ---------------------------------------------------------------
   localparam logic [3:0] SCAN_LAST_LONG  = 4'hF;
   localparam logic [3:0] SCAN_LAST_SHORT = 4'h7;

   typedef struct packed {
      logic       fail_lamp_off;
      logic       soft_reset;
      logic       autoscan_enable;
      logic       signed_format_select;
      logic       test_flag_one;
      logic       single_channel_enable;
      logic       scan_size_select;
      logic [4:0] reserved;
      logic [3:0] poll_channel_select;
   } acs_ctrl_t;

   typedef struct packed {
      logic [6:0] ctrl_mirror;
      logic       calibration_in_progress;
      logic [3:0] zero;
      logic [3:0] poll_channel_select;
   } acs_status_t;

   typedef struct packed {
      logic       start;
      logic [3:0] channel;
   } acs_conv_t;

   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_CONV = 2'b01,
      ACS_CAL  = 2'b10
   } acs_state_t;

endpackage : acs_pkg

// ===== hdl/acs_control.sv
`timescale 1ns/1ps
module acs_control #(
   parameter int unsigned ADDR_W     = 8,
   parameter int unsigned CAL_CYCLES = acs_pkg::CAL_CYCLES
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              conv_done,
   output      acs_pkg::acs_conv_t conv_req,
   output      logic              calibration_in_progress,
   output      logic              fail_lamp_off,
   output      logic              signed_format_select
);

   // ---------------------------------------------------------------
   // Byte-lane folding
   // ---------------------------------------------------------------
   // A halfword at offset 2 arrives on lanes 3:2, so both halves fold
   // onto the one 16-bit control word.
   function automatic logic [7:0] acs_lane(input logic [7:0] old_v,
                                          input logic [31:0] d,
                                          input logic [3:0] s,
                                          input logic hi);
      logic [7:0] v;
      v = old_v;
      if (s[{1'b0, hi}]) v = hi ? d[15:8] : d[7:0];
      if (s[{1'b1, hi}]) v = hi ? d[31:24] : d[23:16];
      return v;
   endfunction : acs_lane

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   acs_pkg::acs_ctrl_t  ctrl;
   acs_pkg::acs_state_t state;
   logic [ADDR_W-1:0]   aw_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   // Ready outputs are flops; the held flags are just their inverse
   wire logic           aw_held = !s_axi_awready;
   wire logic           w_held  = !s_axi_wready;
   logic                soft_pend;
   logic [31:0]         cal_cnt;
   logic [3:0]          scan_idx;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire logic [7:0]  aw_off      = 8'(aw_addr);
   wire logic [7:0]  ar_off      = 8'(s_axi_araddr);
   wire logic        aw_is_ctrl  = (aw_off <= acs_pkg::CTRL_LAST) &&
                                   (aw_addr[ADDR_W-1:2] == (ADDR_W-2)'(aw_off[7:2]));
   wire logic        ar_is_ctrl  = (ar_off <= acs_pkg::CTRL_LAST) &&
                                   (s_axi_araddr[ADDR_W-1:2] == (ADDR_W-2)'(ar_off[7:2]));
   wire logic        ar_is_stat  = (s_axi_araddr == ADDR_W'(acs_pkg::STAT_OFFSET));
   wire logic        wr_fire     = aw_held && w_held && !s_axi_bvalid;
   wire logic        ctrl_wr     = wr_fire && aw_is_ctrl;
   wire logic        rd_fire     = s_axi_arvalid && s_axi_arready;
   wire logic [15:0] next_ctrl_w = {acs_lane(ctrl[15:8], w_data, w_strb, 1'b1),
                                    acs_lane(ctrl[7:0], w_data, w_strb, 1'b0)};
   wire acs_pkg::acs_ctrl_t next_ctrl = next_ctrl_w;
   wire logic        both_on     = ctrl.autoscan_enable && ctrl.single_channel_enable;
   wire logic        scan_go     = ctrl.autoscan_enable && !both_on;
   wire logic        poll_go     = ctrl.single_channel_enable && !both_on;
   wire logic [3:0]  scan_last   = ctrl.scan_size_select ? acs_pkg::SCAN_LAST_SHORT
                                                         : acs_pkg::SCAN_LAST_LONG;
   wire logic [3:0]  next_scan   = (scan_idx >= scan_last) ? 4'h0 : scan_idx + 4'h1;
   wire logic [3:0]  start_chan  = poll_go ? ctrl.poll_channel_select : scan_idx;

   // Status word: every bit is either live or a constant
   wire acs_pkg::acs_status_t status = '{
      ctrl_mirror:             ctrl[15:9],
      calibration_in_progress: calibration_in_progress,
      zero:                    4'h0,
      poll_channel_select:     ctrl.poll_channel_select
   };

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_addr      <= '0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= acs_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held) begin
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_is_ctrl ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   // Write-only control space answers zero rather than an error, so
   // drivers that probe the block do not fault.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= acs_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= ar_is_stat ? {16'h0000, status} : 32'h0000_0000;
         s_axi_rresp  <= (ar_is_stat || ar_is_ctrl) ? acs_pkg::RESP_OKAY
                                                    : acs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Control word
   // ---------------------------------------------------------------
   // Reserved bits are not stored, so they read back as zero whatever
   // software wrote. Soft reset clears the word itself too.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl      <= acs_pkg::CTRL_RESET;
         soft_pend <= 1'b0;
      end else begin
         soft_pend <= 1'b0;
         if (ctrl_wr) begin
            if (next_ctrl.soft_reset) begin
               ctrl      <= acs_pkg::CTRL_RESET;
               soft_pend <= 1'b1;
            end else begin
               ctrl          <= next_ctrl;
               ctrl.reserved <= 5'h00;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequencer and calibration
   // ---------------------------------------------------------------
   // Calibration runs after any reset; it holds off conversions. A
   // conversion under way when a plain write drops autoscan is still completed; a soft reset abandons it.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state                   <= acs_pkg::ACS_CAL;
         cal_cnt                 <= 32'(CAL_CYCLES);
         calibration_in_progress <= 1'b1;
         scan_idx                <= 4'h0;
         conv_req                <= '0;
      end else if (soft_pend) begin
         state                   <= acs_pkg::ACS_CAL;
         cal_cnt                 <= 32'(CAL_CYCLES);
         calibration_in_progress <= 1'b1;
         scan_idx                <= 4'h0;
         conv_req                <= '0;
      end else begin
         conv_req.start <= 1'b0;
         case (state)
            acs_pkg::ACS_CAL: begin
               if (cal_cnt <= 32'h0000_0001) begin
                  state                   <= acs_pkg::ACS_IDLE;
                  calibration_in_progress <= 1'b0;
               end
               cal_cnt <= cal_cnt - 32'h0000_0001;
            end
            acs_pkg::ACS_IDLE: begin
               if (!scan_go) scan_idx <= 4'h0;
               if (scan_go || poll_go) begin
                  conv_req.start   <= 1'b1;
                  conv_req.channel <= start_chan;
                  state            <= acs_pkg::ACS_CONV;
               end
            end
            acs_pkg::ACS_CONV: begin
               if (conv_done) begin
                  state <= acs_pkg::ACS_IDLE;
                  if (scan_go) scan_idx <= next_scan;
               end
            end
            default: state <= acs_pkg::ACS_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fail_lamp_off        <= 1'b0;
         signed_format_select <= 1'b0;
      end else begin
         fail_lamp_off        <= ctrl.fail_lamp_off;
         signed_format_select <= ctrl.signed_format_select;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking acs_cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_scan_done;
      state == acs_pkg::ACS_CONV && conv_done && scan_go && !soft_pend;
   endsequence

   sequence s_ctrl_write;
      ctrl_wr && !next_ctrl.soft_reset;
   endsequence

   property p_scan_wrap;
      s_scan_done and (scan_idx == scan_last) |=> scan_idx == 4'h0;
   endproperty
   a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap");

   property p_scan_step;
      s_scan_done and (scan_idx < scan_last) |=> scan_idx == $past(scan_idx) + 4'h1;
   endproperty
   a_scan_step: assert property (p_scan_step) else $error("scan did not step");

   property p_poll_chan;
      state == acs_pkg::ACS_IDLE && poll_go && !soft_pend
         |=> conv_req.start && conv_req.channel == $past(ctrl.poll_channel_select);
   endproperty
   a_poll_chan: assert property (p_poll_chan)
      else $error("poll channel wrong");

   property p_both_idle;
      both_on |=> !conv_req.start;
   endproperty
   a_both_idle: assert property (p_both_idle) else $error("start with both modes");

   property p_reserved_zero;
      s_ctrl_write |=> ctrl.reserved == 5'h00 &&
         ctrl.poll_channel_select == $past(next_ctrl_w[3:0]);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("ctrl write wrong");

   property p_stat_read;
      rd_fire && ar_is_stat |=> s_axi_rvalid && s_axi_rdata[7:4] == 4'h0 &&
         s_axi_rdata[15:9] == $past(ctrl[15:9]) && s_axi_rdata[3:0] == $past(ctrl[3:0]) &&
         s_axi_rdata[8] == $past(calibration_in_progress);
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("status word wrong");

   property p_ctrl_unread;
      rd_fire && ar_is_ctrl |=> s_axi_rdata == 32'h0000_0000;
   endproperty
   a_ctrl_unread: assert property (p_ctrl_unread) else $error("control readable");

   property p_cal_busy;
      soft_pend |=> calibration_in_progress [*2];
   endproperty
   a_cal_busy: assert property (p_cal_busy) else $error("calibration flag low");

   property p_cal_state;
      calibration_in_progress == (state == acs_pkg::ACS_CAL);
   endproperty
   a_cal_state: assert property (p_cal_state) else $error("calibration flag mismatch");

   property p_read_clean;
      rd_fire && !ctrl_wr |=> ctrl == $past(ctrl);
   endproperty
   a_read_clean: assert property (p_read_clean) else $error("read changed control");

   property p_write_resp;
      aw_held && w_held && !s_axi_bvalid |=> s_axi_bvalid;
   endproperty
   a_write_resp: assert property (p_write_resp) else $error("no write response");

endmodule : acs_control

// ===== tb/acs_control_tb.sv
`timescale 1ns/1ps
`define chk(got, exp, msg) begin compares++; if ((got) !== (exp)) begin err_total++; \
   $display("BAD %0t %s got %h exp %h", $time, msg, got, exp); end end
module acs_control_tb;
   // -----------------------------------------------------------
   // Clock, reset and design
   // -----------------------------------------------------------
   localparam int unsigned CAL = 20;
   logic               ref_clk = 1'b0;
   logic               rst_n   = 1'b0;
   logic [7:0]         awaddr  = 8'h00;
   logic               awvalid = 1'b0;
   logic               awready;
   logic [31:0]        wdata   = 32'h0000_0000;
   logic [3:0]         wstrb   = 4'h0;
   logic               wvalid  = 1'b0;
   logic               wready;
   logic [1:0]         bresp;
   logic               bvalid;
   logic               bready  = 1'b0;
   logic [7:0]         araddr  = 8'h00;
   logic               arvalid = 1'b0;
   logic               arready;
   logic [31:0]        rdata;
   logic [1:0]         rresp;
   logic               rvalid;
   logic               rready  = 1'b0;
   logic               conv_done = 1'b0;
   acs_pkg::acs_conv_t conv_req;
   logic               calibration_in_progress;
   logic               fail_lamp_off;
   logic               signed_format_select;
   int                 err_total = 0;
   int                 compares  = 0;

   always #5 ref_clk = ~ref_clk;

   acs_control #(.ADDR_W(8), .CAL_CYCLES(CAL)) acs_control_i (
      .ref_clk(ref_clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .conv_done(conv_done), .conv_req(conv_req),
      .calibration_in_progress(calibration_in_progress),
      .fail_lamp_off(fail_lamp_off), .signed_format_select(signed_format_select));

   // -----------------------------------------------------------
   // Bus and converter tasks
   // -----------------------------------------------------------
   // Expected status built from the control word, not from the design
   function automatic logic [31:0] stat(input logic [15:0] c, input logic cal);
      return {16'h0000, c[15], 1'b0, c[13:9], cal, 4'h0, c[3:0]};
   endfunction : stat

   task automatic complete_run;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run

   task automatic give_up;
      err_total++;
      $display("BAD %0t wait limit reached", $time);
      complete_run;
   endtask : give_up

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 100);
      if (n >= 100) give_up;
      // Ready is high again once bvalid shows, so back-to-back calls never drive it twice in one step
      `chk(bresp, r, "write response")
   endtask : axi_wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      if (n >= 100) give_up;
      `chk(rresp, r, "read response")
      `chk(rdata, d, "read data")
   endtask : rd_chk

   // Waits for a start pulse; answers at once only when asked to
   task automatic conv(input logic [3:0] ch, input logic ans);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (conv_req.start !== 1'b1 && n < 200);
      if (n >= 200) give_up;
      `chk(conv_req.channel, ch, "channel")
      if (ans) begin
         conv_done <= 1'b1;
         @(posedge ref_clk);
         conv_done <= 1'b0;
      end
   endtask : conv

   task automatic done_pulse;
      conv_done <= 1'b1;
      @(posedge ref_clk);
      conv_done <= 1'b0;
   endtask : done_pulse

   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         `chk(conv_req.start, 1'b0, "unexpected start")
      end
   endtask : quiet

   task automatic wait_cal;
      int n;
      n = 0;
      while (calibration_in_progress !== 1'b0 && n < CAL + 50) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= CAL + 50) give_up;
      `chk(n >= CAL - 8, 1'b1, "calibration too short")
   endtask : wait_cal

   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd_chk(8'h10, stat(16'h0000, 1'b1), 2'h0);
      wait_cal;
      rd_chk(8'h10, stat(16'h0000, 1'b0), 2'h0);
      $display("test calibration done");

      // Reserved bits written as ones must not show up anywhere
      axi_wr(8'h00, 32'h0000_9BF5, 4'h3, 2'h0);
      rd_chk(8'h10, stat(16'h9BF5, 1'b0), 2'h0);
      `chk(fail_lamp_off, 1'b1, "lamp")
      `chk(signed_format_select, 1'b1, "format")
      axi_wr(8'h04, 32'h0000_003C, 4'h1, 2'h0);
      rd_chk(8'h10, stat(16'h9B3C, 1'b0), 2'h0);
      axi_wr(8'h0C, 32'h0800_0000, 4'h8, 2'h0);
      rd_chk(8'h10, stat(16'h083C, 1'b0), 2'h0);
      axi_wr(8'h08, 32'h0007_0000, 4'h4, 2'h0);
      rd_chk(8'h10, stat(16'h0807, 1'b0), 2'h0);
      `chk(fail_lamp_off, 1'b0, "lamp")
      rd_chk(8'h00, 32'h0000_0000, 2'h0);
      rd_chk(8'h20, 32'h0000_0000, 2'h2);
      axi_wr(8'h20, 32'h0000_FFFF, 4'hF, 2'h2);
      rd_chk(8'h10, stat(16'h0807, 1'b0), 2'h0);
      axi_wr(8'h00, 32'h0000_0000, 4'h3, 2'h0);
      $display("test register map done");

      axi_wr(8'h00, 32'h0000_0400, 4'h3, 2'h0);
      for (int c = 0; c < 16; c++) begin
         conv(4'(c), 1'b1);
         conv(4'(c), 1'b0);
         axi_wr(8'h00, (c == 15) ? 32'h0000_0000 : 32'h0000_0400 | 32'(c + 1), 4'h3, 2'h0);
         done_pulse;
      end
      quiet(20);
      $display("test single channel done");

      axi_wr(8'h00, 32'h0000_2200, 4'h3, 2'h0);
      for (int i = 0; i < 8; i++) conv(4'(i), 1'b1);
      conv(4'h0, 1'b0);
      rd_chk(8'h10, stat(16'h2200, 1'b0), 2'h0);
      done_pulse;
      conv(4'h1, 1'b0);
      axi_wr(8'h00, 32'h0000_0000, 4'h3, 2'h0);
      done_pulse;
      quiet(10);
      axi_wr(8'h00, 32'h0000_2000, 4'h3, 2'h0);
      for (int i = 0; i < 16; i++) conv(4'(i), 1'b1);
      conv(4'h0, 1'b0);
      axi_wr(8'h00, 32'h0000_0000, 4'h3, 2'h0);
      done_pulse;
      quiet(10);
      $display("test autoscan done");

      axi_wr(8'h00, 32'h0000_2400, 4'h3, 2'h0);
      quiet(20);
      axi_wr(8'h00, 32'h0000_0000, 4'h3, 2'h0);
      $display("test both enables done");

      // Soft reset lands mid-conversion; the scan must not resume afterwards
      axi_wr(8'h00, 32'h0000_B000, 4'h3, 2'h0);
      conv(4'h0, 1'b0);
      `chk(fail_lamp_off, 1'b1, "lamp")
      axi_wr(8'h00, 32'h0000_4000, 4'h3, 2'h0);
      rd_chk(8'h10, stat(16'h0000, 1'b1), 2'h0);
      wait_cal;
      rd_chk(8'h10, stat(16'h0000, 1'b0), 2'h0);
      `chk(fail_lamp_off, 1'b0, "lamp")
      `chk(signed_format_select, 1'b0, "format")
      quiet(10);
      $display("test soft reset done");
      complete_run;
   end

   initial begin
      repeat (50000) @(posedge ref_clk);
      give_up;
   end
endmodule : acs_control_tb
